/* File: mmb_defs.vh */
// Constants for the message mailbox register front end.
// Assumes inclusion by the mailbox design file only.
`ifndef MMB_DEFS_VH
`define MMB_DEFS_VH
`define MMB_BASE_ADDR     32'h40016000
`define MMB_WIN_MASK      32'hFFFFF000
`define MMB_OFF_CTRL      12'h000
`define MMB_OFF_STAT      12'h004
`define MMB_OFF_IEN       12'h008
`define MMB_OFF_BYTE      12'h010
`define MMB_OFF_WORD      12'h014
`define MMB_OFF_MBYTE     12'h018
`define MMB_OFF_MWORD     12'h01C
`define MMB_CTRL_LOOP     5
`define MMB_CTRL_EN       4
`define MMB_CTRL_RXW      3
`define MMB_CTRL_TXW      2
`define MMB_CTRL_FBUSY    1
`define MMB_CTRL_FREQ     0
`define MMB_ST_CMD        7
`define MMB_ST_UNDER      3
`define MMB_ST_OVER       2
`define MMB_ST_RXOK       1
`define MMB_ST_TXOK       0
`define MMB_CTRL_RST      8'h20
`define MMB_FLUSH_CYC     4'h4
`endif

/* File: mmb_regs.v */
// Message mailbox register front end: APB slave, control/status, two byte FIFOs.
// Assumes rst_n comes from the soft-reset register bit; peer and DMA sit outside.
// Behaviour
// - Control bit 5 loopback, resets to one
// - Control bit 4 enable, resets to zero
// - Control bit 3 selects receive read width
// - Receive request and flag follow receive width
// - Control bit 2 selects transmit write width
// - Transmit request and flag follow transmit width
// - Control bit 1 shows flush in progress
// - Writing one to bit 0 starts flush
// - Flush completion never signalled early
// - Decode 4 KB window and register offsets
// - Status event bits clear on write one
// - Occupancy flags track live FIFO state
// - Status bit 7 shows head command marker
// - Overflow bit 2, underflow bit 3
// - Word ports set width four (transmit writes only while enabled), byte ports one
// - Marker word sends low byte first, marked
`include "mmb_defs.vh"
module mmb_regs #(
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire [8:0]  tx_out_data,
    output wire        tx_out_valid,
    input  wire        tx_out_ready,
    input  wire [8:0]  rx_in_data,
    input  wire        rx_in_valid,
    output wire        rx_in_ready,
    output wire        tx_dma_request,
    output wire        rx_dma_request,
    output wire        mailbox_irq,
    output wire        loopback_mode,
    output wire        mailbox_enabled
);
    localparam [AW:0] FOUR = 4;
    // One-hot flush states
    localparam [1:0]  FL_IDLE = 2'b01;
    localparam [1:0]  FL_BUSY = 2'b10;

    reg  [5:0]     ctrl_q;
    reg  [7:0]     ien_q;
    reg            over_q;
    reg            under_q;
    reg  [3:0]     flush_cnt_q;
    reg  [3:0]     flush_cnt_d;
    reg  [1:0]     flush_st_q;
    reg  [1:0]     flush_st_d;
    reg  [8:0]     txm_q [0:DEPTH-1];
    reg  [8:0]     rxm_q [0:DEPTH-1];
    reg  [AW-1:0]  tx_wp_q;
    reg  [AW-1:0]  tx_rp_q;
    reg  [AW:0]    tx_cnt_q;
    reg  [AW-1:0]  rx_wp_q;
    reg  [AW-1:0]  rx_rp_q;
    reg  [AW:0]    rx_cnt_q;
    reg  [8:0]     skid_data_q [0:1];
    reg  [1:0]     skid_cnt_q;
    reg            skid_rp_q;
    reg            skid_wp_q;
    reg  [7:0]     rd_mux;

    wire        acc     = psel & penable;
    wire        in_win  = (paddr & `MMB_WIN_MASK) == `MMB_BASE_ADDR;
    wire [11:0] off     = paddr[11:0];
    wire        wr      = acc & pwrite & in_win;
    wire        rd      = acc & ~pwrite & in_win;
    wire        is_word = (off == `MMB_OFF_WORD) | (off == `MMB_OFF_MWORD);
    wire        is_byte = (off == `MMB_OFF_BYTE) | (off == `MMB_OFF_MBYTE);
    wire        is_mark = (off == `MMB_OFF_MBYTE) | (off == `MMB_OFF_MWORD);
    wire        fbusy   = flush_st_q[1];
    wire        en      = ctrl_q[`MMB_CTRL_EN];
    wire        loop    = ctrl_q[`MMB_CTRL_LOOP];

    // Register selects within the window
    wire        sel_ctrl = off == `MMB_OFF_CTRL;
    wire        sel_stat = off == `MMB_OFF_STAT;
    wire        sel_ien  = off == `MMB_OFF_IEN;
    wire        flush_go = wr & sel_ctrl & pwdata[`MMB_CTRL_FREQ];

    // Room and fill judged at the width actually moved
    wire [AW:0] tx_free = DEPTH[AW:0] - tx_cnt_q;
    wire        tx_ok   = ctrl_q[`MMB_CTRL_TXW] ? (tx_free >= FOUR) : (tx_free != 0);
    wire        rx_ok   = ctrl_q[`MMB_CTRL_RXW] ? (rx_cnt_q >= FOUR) : (rx_cnt_q != 0);
    wire        tx_push = wr & (is_word | is_byte) & en;
    wire        tx_fits = is_word ? (tx_free >= FOUR) : (tx_free != 0);
    wire        rx_pop  = rd & (is_word | is_byte);
    wire        rx_has  = is_word ? (rx_cnt_q >= FOUR) : (rx_cnt_q != 0);
    // Accepted write moves one byte or a whole word; pushes while disabled are dropped
    wire        tx_wr_ok = tx_push & tx_fits;
    wire [2:0]  tx_wstep = tx_wr_ok ? (is_word ? 3'd4 : 3'd1) : 3'd0;

    // Output skid buffer: a stall by the peer loses no byte
    wire        skid_full = skid_cnt_q == 2'd2;
    wire        tx_drain  = (tx_cnt_q != 0) & ~skid_full & ~loop & en & ~fbusy;
    wire        skid_out  = tx_out_ready & (skid_cnt_q != 0);
    // Loopback moves transmit bytes straight into the receive FIFO
    wire        lb_move   = loop & en & ~fbusy & (tx_cnt_q != 0) & (rx_cnt_q != DEPTH[AW:0]);
    wire        rx_space  = rx_cnt_q != DEPTH[AW:0];
    wire        rx_take   = rx_in_valid & rx_space & ~loop & en & ~fbusy;
    wire        tx_rd     = tx_drain | lb_move;

    assign tx_out_valid    = skid_cnt_q != 0;
    assign tx_out_data     = skid_data_q[skid_rp_q];
    assign rx_in_ready     = rx_space & ~loop & en & ~fbusy;
    assign tx_dma_request  = tx_ok & en;
    assign rx_dma_request  = rx_ok & en;
    assign pready          = 1'b1;
    assign pslverr         = 1'b0;
    assign loopback_mode   = loop;
    assign mailbox_enabled = en;

    wire       st_cmd = rxm_q[rx_rp_q][8] & (rx_cnt_q != 0);
    // Bits 6..4 report the peer-side transfer path, which this block leaves out
    wire [7:0] status = {st_cmd, 3'b000, under_q, over_q, rx_ok, tx_ok};
    assign mailbox_irq = |(status & ien_q);

    // Word read gathers four bytes, oldest in the low lane
    wire [31:0] rx_word = {rxm_q[rx_rp_q+3'd3][7:0], rxm_q[rx_rp_q+3'd2][7:0],
                           rxm_q[rx_rp_q+3'd1][7:0], rxm_q[rx_rp_q][7:0]};

    always @* begin
        case (off)
            `MMB_OFF_CTRL: rd_mux = {2'b00, ctrl_q[5:2], fbusy, fbusy};
            `MMB_OFF_STAT: rd_mux = status;
            `MMB_OFF_IEN:  rd_mux = ien_q;
            default:       rd_mux = 8'h00;
        endcase
    end

    // Flush sequencer: held busy for a fixed count so completion never shows early
    always @* begin
        flush_st_d  = flush_st_q;
        flush_cnt_d = flush_cnt_q;
        case (flush_st_q)
            FL_IDLE: begin
                if (flush_go) begin
                    flush_st_d  = FL_BUSY;
                    flush_cnt_d = `MMB_FLUSH_CYC;
                end
            end
            FL_BUSY: begin
                if (flush_go)
                    flush_cnt_d = `MMB_FLUSH_CYC;
                else if (flush_cnt_q == 4'h1) begin
                    flush_st_d  = FL_IDLE;
                    flush_cnt_d = 4'h0;
                end else
                    flush_cnt_d = flush_cnt_q - 4'h1;
            end
            default: begin
                flush_st_d  = FL_IDLE;
                flush_cnt_d = 4'h0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_st_q  <= FL_IDLE;
            flush_cnt_q <= 4'h0;
        end else begin
            flush_st_q  <= flush_st_d;
            flush_cnt_q <= flush_cnt_d;
        end
    end

    // Read data is registered: it shows on the cycle after the access phase
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            prdata <= 32'h00000000;
        else if (rd) begin
            if (is_word)
                prdata <= rx_word;
            else if (is_byte)
                prdata <= {24'h000000, rxm_q[rx_rp_q][7:0]};
            else
                prdata <= {24'h000000, rd_mux};
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 6'h20;
            ien_q  <= 8'h00;
        end else begin
            if (wr & sel_ctrl)
                ctrl_q[5:2] <= pwdata[5:2];
            if (wr & sel_ien)
                ien_q <= pwdata[7:0];
            if (tx_push | (wr & is_byte))
                ctrl_q[`MMB_CTRL_TXW] <= is_word;
            if (rx_pop)
                ctrl_q[`MMB_CTRL_RXW] <= is_word;
        end
    end

    // Set beats clear in the same cycle, so no event is lost to a racing clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            over_q  <= 1'b0;
            under_q <= 1'b0;
        end else begin
            over_q  <= (tx_push & ~tx_fits) |
                       (over_q & ~(wr & sel_stat & pwdata[`MMB_ST_OVER]));
            under_q <= (rx_pop & ~rx_has) |
                       (under_q & ~(wr & sel_stat & pwdata[`MMB_ST_UNDER]));
        end
    end

    integer k;

    // Transmit FIFO
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_wp_q  <= {AW{1'b0}};
            tx_rp_q  <= {AW{1'b0}};
            tx_cnt_q <= {(AW+1){1'b0}};
            for (k = 0; k < DEPTH; k = k + 1)
                txm_q[k] <= 9'h000;
        end else if (fbusy) begin
            tx_wp_q  <= {AW{1'b0}};
            tx_rp_q  <= {AW{1'b0}};
            tx_cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (tx_push & tx_fits) begin
                if (is_word) begin
                    txm_q[tx_wp_q]      <= {is_mark, pwdata[7:0]};
                    txm_q[tx_wp_q+3'd1] <= {1'b0, pwdata[15:8]};
                    txm_q[tx_wp_q+3'd2] <= {1'b0, pwdata[23:16]};
                    txm_q[tx_wp_q+3'd3] <= {1'b0, pwdata[31:24]};
                end else
                    txm_q[tx_wp_q] <= {is_mark, pwdata[7:0]};
            end
            // Pointers wrap at the depth; the count alone tells full from empty
            tx_wp_q  <= tx_wp_q + tx_wstep;
            tx_rp_q  <= tx_rp_q + {2'b00, tx_rd};
            tx_cnt_q <= tx_cnt_q + {1'b0, tx_wstep} - {3'b000, tx_rd};
        end
    end

    // Receive FIFO
    wire        rx_wen = rx_take | lb_move;
    wire [8:0]  rx_win = loop ? txm_q[tx_rp_q] : rx_in_data;
    wire        rx_ren = rx_pop & rx_has;
    // A short read pops nothing; it raises the underflow event and still sets the receive width bit
    wire [2:0]  rx_rstep = rx_ren ? (is_word ? 3'd4 : 3'd1) : 3'd0;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wp_q  <= {AW{1'b0}};
            rx_rp_q  <= {AW{1'b0}};
            rx_cnt_q <= {(AW+1){1'b0}};
            for (k = 0; k < DEPTH; k = k + 1)
                rxm_q[k] <= 9'h000;
        end else if (fbusy) begin
            rx_wp_q  <= {AW{1'b0}};
            rx_rp_q  <= {AW{1'b0}};
            rx_cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (rx_wen)
                rxm_q[rx_wp_q] <= rx_win;
            rx_wp_q  <= rx_wp_q + {2'b00, rx_wen};
            rx_rp_q  <= rx_rp_q + rx_rstep;
            rx_cnt_q <= rx_cnt_q + {3'b000, rx_wen} - {1'b0, rx_rstep};
        end
    end

    // Two-entry skid buffer toward the peer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skid_cnt_q     <= 2'd0;
            skid_rp_q      <= 1'b0;
            skid_wp_q      <= 1'b0;
            skid_data_q[0] <= 9'h000;
            skid_data_q[1] <= 9'h000;
        end else if (fbusy) begin
            skid_cnt_q <= 2'd0;
            skid_rp_q  <= 1'b0;
            skid_wp_q  <= 1'b0;
        end else begin
            if (tx_drain)
                skid_data_q[skid_wp_q] <= txm_q[tx_rp_q];
            skid_wp_q  <= skid_wp_q ^ tx_drain;
            skid_rp_q  <= skid_rp_q ^ skid_out;
            skid_cnt_q <= skid_cnt_q + {1'b0, tx_drain} - {1'b0, skid_out};
        end
    end
endmodule // mmb_regs

/* File: mmb_monitor.sv */
// Port-level assertions for the mailbox register front end.
// Assumes it is bound to every mmb_regs instance.
module mmb_monitor (
    input logic        clk,
    input logic        rst_n,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic [8:0]  tx_out_data,
    input logic        tx_out_valid,
    input logic        tx_out_ready,
    input logic        rx_in_ready,
    input logic        tx_dma_request,
    input logic        rx_dma_request,
    input logic        loopback_mode,
    input logic        mailbox_enabled
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable;
    wire cw  = acc && pwrite && paddr == 32'h40016000;
    wire cr  = acc && !pwrite && paddr == 32'h40016000;
    loop_bit_a: assert property (cw |=> loopback_mode == $past(pwdata[5]))
        else $error("loopback bit wrong");
    en_bit_a: assert property (cw |=> mailbox_enabled == $past(pwdata[4]))
        else $error("enable bit wrong");
    dma_gate_a: assert property (!mailbox_enabled |-> !tx_dma_request && !rx_dma_request)
        else $error("request while disabled");
    loop_stall_a: assert property (loopback_mode |-> !rx_in_ready)
        else $error("link open in loopback");
    out_win_a: assert property (acc && !pwrite && paddr[31:12] != 20'h40016 |=> $stable(prdata))
        else $error("read outside window answered");
    tx_hold_a: assert property (tx_out_valid && !tx_out_ready && !$past(cw && pwdata[0]) |=> tx_out_valid && $stable(tx_out_data))
        else $error("stalled byte changed");
    flush_busy_a: assert property (cw && pwdata[0] |=> !rx_in_ready [*3])
        else $error("flush ended early");
    resv_zero_a: assert property (cr |=> prdata[31:6] == 26'h0)
        else $error("reserved control bits set");
    cover property (cw && pwdata[0]);
    cover property (tx_out_valid && !tx_out_ready);
    cover property (rx_dma_request);
endmodule // mmb_monitor
bind mmb_regs mmb_monitor u_mmb_monitor (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .rx_in_ready(rx_in_ready), .tx_dma_request(tx_dma_request),
    .rx_dma_request(rx_dma_request), .loopback_mode(loopback_mode),
    .mailbox_enabled(mailbox_enabled));

/* File: mmb_peer.sv */
// Behavioural peer: sink for sent bytes, source of received bytes.
// Assumes the bench fills snd and sets stall by hierarchical reference.
module mmb_peer (
    input  logic       clk,
    input  logic [8:0] tx_out_data,
    input  logic       tx_out_valid,
    output logic       tx_out_ready,
    output logic [8:0] rx_in_data,
    output logic       rx_in_valid,
    input  logic       rx_in_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       stall = 1'b0;
    logic [8:0] got[$];
    logic [8:0] snd[$];
    initial begin
        tx_out_ready = 1'b1;
        rx_in_valid = 1'b0;
        rx_in_data = 9'h000;
    end
    always @(posedge clk) begin
        if (tx_out_valid && tx_out_ready) got.push_back(tx_out_data);
        if (rx_in_valid && rx_in_ready) void'(snd.pop_front());
        #1;
        tx_out_ready = !stall;
        rx_in_valid = snd.size() != 0;
        // Idle data toggles so a stale byte is never mistaken for a fresh one
        rx_in_data = rx_in_valid ? snd[0] : ~rx_in_data;
    end
endmodule // mmb_peer

/* File: mmb_regs_tb.sv */
// Self-checking bench for mmb_regs with the behavioural peer.
// Assumes the checker is bound from its own file.
module mmb_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] B = 32'h40016000;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, rd;
    wire  [31:0] prdata;
    wire  [8:0]  txd, rxd;
    wire         txv, txr, rxv, rxr, txq, rxq, irq, lb, en, rdy, err;
    int          fails = 0, checks = 0;
    mmb_regs u_mmb_regs (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy),
        .pslverr(err), .tx_out_data(txd), .tx_out_valid(txv), .tx_out_ready(txr),
        .rx_in_data(rxd), .rx_in_valid(rxv), .rx_in_ready(rxr), .tx_dma_request(txq),
        .rx_dma_request(rxq), .mailbox_irq(irq), .loopback_mode(lb), .mailbox_enabled(en));
    mmb_peer u_mmb_peer (.clk(clk), .tx_out_data(txd), .tx_out_valid(txv),
        .tx_out_ready(txr), .rx_in_data(rxd), .rx_in_valid(rxv), .rx_in_ready(rxr));
    initial forever #50 clk = ~clk;
    task print_verdict;
        if (fails == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Zero-wait APB: setup, access, then read data lands at the access edge
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
        @(posedge clk);
        #1 penable = 1;
        @(posedge clk);
        #1 {psel, penable} = 2'b00;
        rd = prdata;
    endtask
    task t_reset;
        apb(0, B, 0); chk("ctrl", rd, 32'h20);
        apb(0, B + 4, 0); chk("stat", rd, 32'h01);
        apb(0, B + 8, 0); chk("ien", rd, 32'h00);
        apb(0, B + 'hC, 0); chk("hole", rd, 32'h00);
        apb(0, 32'h40017000, 0); chk("outside", rd, 32'h00);
        chk("rdyerr", {rdy, err}, 2'b10);
    endtask
    task t_up;
        apb(1, B, 32'h30);
        apb(1, B, 32'h10);
        chk("en", {lb, en}, 2'b01);
    endtask
    task t_tx;
        u_mmb_peer.stall = 1;
        apb(1, B + 'h1C, 32'h44332211);
        apb(0, B, 0); chk("txw", rd, 32'h14);
        u_mmb_peer.stall = 0;
        for (int i = 0; i < 50 && u_mmb_peer.got.size() < 4; i++) @(posedge clk);
        if (u_mmb_peer.got.size() < 4) begin fails++; print_verdict; end
        for (int i = 0; i < 4; i++) chk("tx", u_mmb_peer.got[i], {i == 0, 8'(i * 'h11 + 'h11)});
    endtask
    task t_ovf;
        u_mmb_peer.stall = 1;
        repeat (12) apb(1, B + 'h10, 32'h5A);
        chk("txq", txq, 1'b0);
        apb(0, B + 4, 0); chk("ovf", rd & 32'h5, 32'h4);
        apb(1, B + 4, 0); apb(0, B + 4, 0); chk("w0", rd & 32'h4, 32'h4);
        apb(1, B + 4, 4); apb(0, B + 4, 0); chk("w1", rd & 32'h4, 32'h0);
        apb(1, B, 32'h11); chk("busy", rxr, 1'b0);
        apb(0, B, 0); chk("fl", rd[1:0], 2'b11);
        repeat (6) @(posedge clk);
        apb(0, B, 0); chk("done", rd, 32'h10);
        apb(0, B + 4, 0); chk("txok", rd & 32'h1, 32'h1);
        u_mmb_peer.stall = 0;
    endtask
    task t_rx;
        u_mmb_peer.snd = {9'h1AA, 9'h0BB, 9'h0CC, 9'h0DD};
        repeat (12) @(posedge clk);
        apb(0, B + 4, 0); chk("head", rd & 32'h82, 32'h82);
        apb(0, B + 'h14, 0); chk("word", rd, 32'hDDCCBBAA);
        u_mmb_peer.snd = {9'h001, 9'h002, 9'h003};
        repeat (12) @(posedge clk);
        chk("rxq1", rxq, 1'b0);
        apb(0, B + 'h10, 0); chk("byte", rd[7:0], 8'h01);
        chk("rxq0", rxq, 1'b1);
        apb(1, B + 8, 8); apb(0, B + 'h14, 0);
        apb(0, B + 4, 0); chk("udf", rd & 32'h8, 32'h8);
        chk("irq", irq, 1'b1);
        apb(1, B + 4, 8); chk("irq0", irq, 1'b0);
    endtask
    task t_loop;
        apb(1, B, 32'hF1);
        repeat (6) @(posedge clk);
        apb(0, B, 0); chk("resv", rd, 32'h30);
        apb(1, B + 'h10, 32'h77);
        apb(0, B + 'h10, 0); chk("lb", rd, 32'h77);
        chk("lbgot", u_mmb_peer.got.size(), 4);
        apb(1, B, 32'h10);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        t_reset;
        t_up;
        t_tx;
        t_ovf;
        t_rx;
        t_loop;
        print_verdict;
    end
endmodule // mmb_regs_tb
